/* rtd_top.sv */
// Periodic interrupt divider and modulation control with APB registers
`default_nettype none
// Functional notes
// (RULE1) Modulation writes need lock off, PLL selected
// (RULE2) Accepted modulation write clears lock, osc-up
// (RULE3) Amplitude bits 5:4, rate reference/16
// (RULE4) Amplitude codes: off, 1, 2, 4 percent
// (RULE5) Software avoids modulation with adaptive filter
// (RULE6) Software keeps peak bus frequency legal
// (RULE7) Divider clocked by reference or oscillator
// (RULE8) Stop halts unless pseudo stop, oscillator
// (RULE9) Divider register accessible any time
// (RULE10) Divider write restarts timeout period
// (RULE11) Source select change restarts period
// (RULE12) Bit 7 picks binary or decimal
// (RULE13) Rate bits 6:4; binary zero is off
// (RULE14) Modulus bits 3:0 multiply by value+1
// (RULE15) Binary total is modulus times prescale
// (RULE16) Decimal factors 1000 up to 200000
// (RULE17) Enabled timeout flag raises interrupt
// (RULE18) Source select needs osc-up, cleared on loss
// (RULE19) Timeout sets flag, next period follows
// (RULE20) Unused modulation bits read zero
module rtd_top (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins: ref clock, osc clock, stop, osc up, lock
   input wire logic internal_ref_clock,
   input wire logic crystal_osc_clock,
   input wire logic stop_mode,
   input wire logic osc_up_in,
   input wire logic pll_lock_in,
   // Modulation and interrupt outputs
   output rtd_pkg::rtd_amp_t fm_amplitude,
   output logic fm_step,
   output logic periodic_irq
);
   import rtd_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [RTD_PINS-1:0] pins;
   logic [RTD_PINS-1:0] sync1;
   logic [RTD_PINS-1:0] sync2;
   logic [RTD_PINS-1:0] sync3;
   assign pins = {pll_lock_in, osc_up_in, stop_mode, crystal_osc_clock, internal_ref_clock};

   genvar gi;
   generate
      for (gi = 0; gi < RTD_PINS; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (srst) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
            end else begin
               sync1[gi] <= pins[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
            end
         end
      end
   endgenerate

   wire [RTD_PINS-1:0] rise = sync2 & ~sync3;
   wire [RTD_PINS-1:0] fall = ~sync2 & sync3;

   ////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] pll_modulation_control;
   rtd_rti_t periodic_interrupt_divider_control;
   logic [4:0] cfg;
   logic periodic_timeout_flag;
   logic lock_status;
   logic osc_up_status;
   logic src_prev;

   ////////////////////////////////////////////////////////////////////
   // APB decode
   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire hit_pll = paddr == RTD_ADDR_PLL;
   wire hit_rti = paddr == RTD_ADDR_RTI;
   wire hit_cfg = paddr == RTD_ADDR_CFG;
   wire hit_stat = paddr == RTD_ADDR_STAT;
   wire mapped = hit_pll | hit_rti | hit_cfg | hit_stat;
   wire protection_lock = cfg[RTD_CFG_PROTECTION_LOCK];
   wire pll_clock_select = cfg[RTD_CFG_PLL_CLOCK_SELECT];
   wire periodic_src_select = cfg[RTD_CFG_SRC];
   wire pseudo_stop_select = cfg[RTD_CFG_PSTOP];
   wire periodic_irq_enable = cfg[RTD_CFG_IRQEN];
   wire pll_wr_try = wr & hit_pll;
   // (RULE1) Write gate
   wire pll_wr = pll_wr_try & ~protection_lock & pll_clock_select;
   // (RULE9) Always writable
   wire rti_wr = wr & hit_rti;
   wire cfg_wr = wr & hit_cfg;
   wire stat_wr = wr & hit_stat;

   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_pll) begin
         next_prdata[7:0] = pll_modulation_control;
      end else if (hit_rti) begin
         next_prdata[7:0] = periodic_interrupt_divider_control;
      end else if (hit_cfg) begin
         next_prdata[4:0] = cfg;
      end else if (hit_stat) begin
         next_prdata[2:0] = {osc_up_status, lock_status, periodic_timeout_flag};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= setup ? next_prdata : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Modulation control register
   always_ff @(posedge clk) begin
      if (srst) begin
         pll_modulation_control <= RTD_PLL_RESET;
      end else if (pll_wr) begin
         // (RULE20) Unused bits held zero
         pll_modulation_control <= pwdata[7:0] & RTD_PLL_MASK;
      end
   end

   // (RULE3) Amplitude field drive
   // (RULE4) Code passed unchanged to the modulator
   wire rtd_amp_t amp = pll_modulation_control[RTD_PLL_AMP_LSB +: 2];
   logic [3:0] fm_div;
   always_ff @(posedge clk) begin
      if (srst) begin
         fm_amplitude <= 2'b00;
         fm_div <= 4'h0;
         fm_step <= 1'b0;
      end else begin
         fm_amplitude <= amp;
         fm_step <= (amp != 2'b00) & rise[RTD_PIN_REF] & (fm_div == RTD_FM_DIV_LAST);
         if (amp == 2'b00) begin
            fm_div <= 4'h0;
         end else if (rise[RTD_PIN_REF]) begin
            fm_div <= fm_div + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status and configuration
   always_ff @(posedge clk) begin
      if (srst) begin
         lock_status <= 1'b0;
         osc_up_status <= 1'b0;
      end else begin
         // (RULE2) Cleared by accepted write, set wins
         if (rise[RTD_PIN_LOCK]) begin
            lock_status <= 1'b1;
         end else if (pll_wr | fall[RTD_PIN_LOCK]) begin
            lock_status <= 1'b0;
         end
         if (rise[RTD_PIN_OSCUP]) begin
            osc_up_status <= 1'b1;
         end else if (pll_wr | fall[RTD_PIN_OSCUP]) begin
            osc_up_status <= 1'b0;
         end
      end
   end

   logic [4:0] next_cfg;
   always_comb begin
      next_cfg = cfg;
      if (cfg_wr) begin
         next_cfg = pwdata[4:0];
      end
      // (RULE18) Source select needs oscillator up
      if (!osc_up_status) begin
         next_cfg[RTD_CFG_SRC] = 1'b0;
      end else if (cfg_wr && pwdata[RTD_CFG_SRC] && !cfg[RTD_CFG_SRC]) begin
         next_cfg[RTD_CFG_SRC] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg <= RTD_CFG_RESET;
         periodic_interrupt_divider_control <= RTD_RTI_RESET;
         src_prev <= 1'b0;
      end else begin
         cfg <= next_cfg;
         src_prev <= periodic_src_select;
         if (rti_wr) begin
            periodic_interrupt_divider_control <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Periodic divider
   rtd_rti_t periodic_interrupt_timer;
   assign periodic_interrupt_timer = periodic_interrupt_divider_control;
   // (RULE7) Source clock edge
   wire src_edge = periodic_src_select ? rise[RTD_PIN_OSC] : rise[RTD_PIN_REF];
   // (RULE8) Halt in stop mode
   wire run = ~sync2[RTD_PIN_STOP] | (pseudo_stop_select & periodic_src_select);
   // (RULE13) Binary code zero disables
   wire div_on = periodic_interrupt_timer.dec | (periodic_interrupt_timer.rate != 3'b000);
   // (RULE11) Source change restart
   wire src_chg = src_prev != periodic_src_select;
   // (RULE10) Write restart
   wire restart = rti_wr | src_chg;
   // (RULE12) Binary or decimal prescale
   // (RULE16) Decimal factor table
   wire [4:0] bin_exp = 5'(RTD_BIN_BASE) + {2'b00, periodic_interrupt_timer.rate};
   wire [17:0] dec_last = RTD_DEC_TAB[periodic_interrupt_timer.rate] - 18'd1;
   wire [17:0] bin_last = 18'((18'd1 << bin_exp) - 18'd1);
   wire [17:0] pre_last = periodic_interrupt_timer.dec ? dec_last : bin_last;
   logic [17:0] presc;
   logic [3:0] mod_cnt;
   wire tick = src_edge & run & div_on & ~restart;
   wire pre_wrap = tick & (presc >= pre_last);
   // (RULE14) Modulus multiplies prescale
   // (RULE15) Total is product of both
   wire tc = pre_wrap & (mod_cnt >= periodic_interrupt_timer.modulus);

   always_ff @(posedge clk) begin
      if (srst) begin
         presc <= 18'd0;
         mod_cnt <= 4'h0;
      end else if (restart || !div_on) begin
         presc <= 18'd0;
         mod_cnt <= 4'h0;
      end else if (pre_wrap) begin
         // (RULE19) Next period begins at once
         presc <= 18'd0;
         mod_cnt <= tc ? 4'h0 : mod_cnt + 4'h1;
      end else if (tick) begin
         presc <= presc + 18'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         periodic_timeout_flag <= 1'b0;
         periodic_irq <= 1'b0;
      end else begin
         // (RULE19) Set wins over clear
         if (tc) begin
            periodic_timeout_flag <= 1'b1;
         end else if (stat_wr && pwdata[RTD_STAT_FLAG]) begin
            periodic_timeout_flag <= 1'b0;
         end
         // (RULE17) Interrupt request
         periodic_irq <= periodic_timeout_flag & periodic_irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_pll_refuse;
      pll_wr_try && (protection_lock || !pll_clock_select) |=> $stable(pll_modulation_control);
   endproperty
   a_pll_refuse: assert property (p_pll_refuse) else $error("refused write changed reg"); // RULE1

   property p_pll_clear;
      pll_wr && !rise[RTD_PIN_LOCK] && !rise[RTD_PIN_OSCUP] |=> !lock_status && !osc_up_status;
   endproperty
   a_pll_clear: assert property (p_pll_clear) else $error("status not cleared"); // RULE2

   property p_amp_out;
      1'b1 |=> fm_amplitude == $past(pll_modulation_control[5:4]);
   endproperty
   a_amp_out: assert property (p_amp_out) else $error("amplitude mismatch"); // RULE3

   property p_unused_zero;
      (pll_modulation_control & ~RTD_PLL_MASK) == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits set"); // RULE20

   property p_restart;
      restart |=> presc == 18'd0 && mod_cnt == 4'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("period not restarted"); // RULE10

   property p_halt;
      !run && !restart && div_on |=> $stable(presc) && $stable(mod_cnt);
   endproperty
   a_halt: assert property (p_halt) else $error("counter ran in stop"); // RULE8

   property p_off;
      !periodic_interrupt_timer.dec && periodic_interrupt_timer.rate == 3'b000 |-> !tc;
   endproperty
   a_off: assert property (p_off) else $error("timeout while off"); // RULE13

   property p_flag_irq;
      tc |=> periodic_timeout_flag ##1 (periodic_irq == $past(periodic_irq_enable));
   endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("flag or irq missing"); // RULE17

   property p_src_loss;
      !osc_up_status |=> !periodic_src_select;
   endproperty
   a_src_loss: assert property (p_src_loss) else $error("source kept without osc"); // RULE18

   property p_rti_write;
      rti_wr |=> periodic_interrupt_divider_control == $past(pwdata[7:0]);
   endproperty
   a_rti_write: assert property (p_rti_write) else $error("divider write lost"); // RULE9

   property p_src_count;
      div_on && run && src_edge && !restart && !pre_wrap |=> presc == $past(presc) + 18'd1;
   endproperty
   a_src_count: assert property (p_src_count) else $error("source edge not counted"); // RULE7

   property p_tc_next;
      tc |=> presc == 18'd0 && mod_cnt == 4'h0;
   endproperty
   a_tc_next: assert property (p_tc_next) else $error("next period not begun"); // RULE19

   property p_fm_pulse;
      fm_step |-> fm_amplitude != 2'b00 ##1 !fm_step;
   endproperty
   a_fm_pulse: assert property (p_fm_pulse) else $error("modulation step wrong"); // RULE3
endmodule
`default_nettype wire

/* rtd_pkg.sv */
// Constants, layouts and types of the periodic divider and modulation control
`default_nettype none
package rtd_pkg;
   // Register indexes and byte addresses
   localparam logic [7:0] RTD_IDX_PLL = 8'h3A;
   localparam logic [7:0] RTD_IDX_RTI = 8'h3B;
   localparam logic [7:0] RTD_IDX_CFG = 8'h3C;
   localparam logic [7:0] RTD_IDX_STAT = 8'h3D;
   localparam logic [9:0] RTD_ADDR_PLL = {RTD_IDX_PLL, 2'b00};
   localparam logic [9:0] RTD_ADDR_RTI = {RTD_IDX_RTI, 2'b00};
   localparam logic [9:0] RTD_ADDR_CFG = {RTD_IDX_CFG, 2'b00};
   localparam logic [9:0] RTD_ADDR_STAT = {RTD_IDX_STAT, 2'b00};
   // Field positions
   localparam int RTD_PLL_AMP_LSB = 4;
   localparam logic [7:0] RTD_PLL_MASK = 8'h30;
   localparam int RTD_CFG_SRC = 0;
   localparam int RTD_CFG_PLL_CLOCK_SELECT = 1;
   localparam int RTD_CFG_PSTOP = 2;
   localparam int RTD_CFG_PROTECTION_LOCK = 3;
   localparam int RTD_CFG_IRQEN = 4;
   localparam int RTD_STAT_FLAG = 0;
   localparam int RTD_STAT_LOCK = 1;
   localparam int RTD_STAT_OSCUP = 2;
   // Values after reset
   localparam logic [7:0] RTD_PLL_RESET = 8'h00;
   localparam logic [7:0] RTD_RTI_RESET = 8'h00;
   localparam logic [4:0] RTD_CFG_RESET = 5'h02;
   // Modulation rate divider: last count of the 16 reference edges per modulation step
   localparam logic [3:0] RTD_FM_DIV_LAST = 4'hF;
   // Binary prescale exponent base: code 1 gives 2^10
   localparam int RTD_BIN_BASE = 9;
   // Decimal prescale factors
   localparam logic [17:0] RTD_DEC_TAB [8] = '{
      18'd1000, 18'd2000, 18'd5000, 18'd10000,
      18'd20000, 18'd50000, 18'd100000, 18'd200000};
   // Pin input order
   localparam int RTD_PIN_REF = 0;
   localparam int RTD_PIN_OSC = 1;
   localparam int RTD_PIN_STOP = 2;
   localparam int RTD_PIN_OSCUP = 3;
   localparam int RTD_PIN_LOCK = 4;
   localparam int RTD_PINS = 5;

   typedef struct packed {
      logic dec;
      logic [2:0] rate;
      logic [3:0] modulus;
   } rtd_rti_t;

   typedef logic [1:0] rtd_amp_t;
endpackage
`default_nettype wire

/* tb_rtd_top.sv */
// Self-checking testbench of the periodic divider and modulation control
`default_nettype none
module tb_rtd_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rtd_pkg::*;
   typedef struct packed {
      logic [9:0] a;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [1:0] amp;
      logic err;
   } rtd_row_t;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] periodic_interrupt_timer;
      logic [15:0] cyc;
   } rtd_per_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic internal_ref_clock = 1'b0;
   logic crystal_osc_clock = 1'b0;
   logic stop_mode = 1'b0;
   logic osc_up_in = 1'b0;
   logic pll_lock_in = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   rtd_amp_t fm_amplitude;
   logic fm_step;
   logic periodic_irq;
   logic [31:0] rdat;
   logic rerr;
   int cyc = 0;
   int fail_count = 0;
   int checked = 0;
   rtd_row_t rows [12] = '{
      '{RTD_ADDR_PLL, 8'hFF, 8'h30, 2'h3, 1'b0},
      '{RTD_ADDR_PLL, 8'h1F, 8'h10, 2'h1, 1'b0},
      '{RTD_ADDR_PLL, 8'hE0, 8'h20, 2'h2, 1'b0},
      '{RTD_ADDR_PLL, 8'h00, 8'h00, 2'h0, 1'b0},
      '{RTD_ADDR_CFG, 8'h0B, 8'h0A, 2'h0, 1'b0},
      '{RTD_ADDR_PLL, 8'h10, 8'h00, 2'h0, 1'b0},
      '{RTD_ADDR_RTI, 8'hA5, 8'hA5, 2'h0, 1'b0},
      '{RTD_ADDR_CFG, 8'h10, 8'h10, 2'h0, 1'b0},
      '{RTD_ADDR_PLL, 8'h30, 8'h00, 2'h0, 1'b0},
      '{RTD_ADDR_CFG, 8'h12, 8'h12, 2'h0, 1'b0},
      '{RTD_ADDR_PLL, 8'h20, 8'h20, 2'h2, 1'b0},
      '{10'h3FC, 8'h55, 8'h00, 2'h2, 1'b1}};
   rtd_per_t pers [4] = '{
      '{8'h12, 8'h10, 16'd4096}, '{8'h12, 8'h11, 16'd8192},
      '{8'h12, 8'h90, 16'd8000}, '{8'h13, 8'h10, 16'd6144}};

   rtd_top i_rtd_top (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .internal_ref_clock(internal_ref_clock),
      .crystal_osc_clock(crystal_osc_clock), .stop_mode(stop_mode), .osc_up_in(osc_up_in),
      .pll_lock_in(pll_lock_in), .fm_amplitude(fm_amplitude), .fm_step(fm_step),
      .periodic_irq(periodic_irq));

   ////////////////////////////////////////////////////////////////////////////////
   // Clocks: system, reference (4 cycles), oscillator (6 cycles)
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      internal_ref_clock <= cyc[1];
      crystal_osc_clock <= (cyc % 6) >= 3;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checking and bus tasks
   task automatic results();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk("pready", pready, 1'b1); // bus answer
         results();
      end
      @(posedge clk);
   endtask
   task automatic wait_sig(input logic which, input int lim, output int t);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((which ? fm_step : periodic_irq) !== 1'b1 && n < lim);
      t = cyc;
      if (n >= lim) begin
         chk("pulse wait", 1'b0, 1'b1); // pulse due
         results();
      end
   endtask
   task automatic period(input logic [7:0] c, input logic [7:0] r, output int d);
      int t1;
      int t2;
      apb(1'b1, RTD_ADDR_CFG, c);
      apb(1'b1, RTD_ADDR_RTI, r);
      apb(1'b1, RTD_ADDR_STAT, 8'h01);
      wait_sig(1'b0, 20000, t1);
      apb(1'b1, RTD_ADDR_STAT, 8'h01);
      wait_sig(1'b0, 20000, t2);
      d = t2 - t1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int t;
      int d;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].wd);
         apb(1'b0, rows[i].a, 8'h00);
         chk("read back", rdat, {24'h0, rows[i].rd}); // fields
         chk("slave error", rerr, rows[i].err); // bus answer
         chk("amplitude", fm_amplitude, rows[i].amp); // amplitude
      end
      wait_sig(1'b1, 200, t);
      wait_sig(1'b1, 200, d);
      chk("modulation step", d - t, 64); // rate step
      osc_up_in <= 1'b1;
      pll_lock_in <= 1'b1;
      repeat (8) @(posedge clk);
      foreach (pers[i]) begin
         period(pers[i].cfg, pers[i].periodic_interrupt_timer, d);
         chk("period", d, pers[i].cyc);
      end
      apb(1'b1, RTD_ADDR_CFG, 8'h12);
      apb(1'b1, RTD_ADDR_RTI, 8'h00);
      apb(1'b1, RTD_ADDR_STAT, 8'h01);
      repeat (3000) @(posedge clk);
      chk("divider off", periodic_irq, 1'b0); // code off
      stop_mode <= 1'b1;
      apb(1'b1, RTD_ADDR_CFG, 8'h12);
      apb(1'b1, RTD_ADDR_RTI, 8'h10);
      repeat (6000) @(posedge clk);
      chk("stop halt", periodic_irq, 1'b0); // stop halts
      stop_mode <= 1'b0;
      wait_sig(1'b0, 4400, t);
      stop_mode <= 1'b1;
      period(8'h17, 8'h10, d);
      chk("pseudo stop", d, 6144); // pseudo stop
      stop_mode <= 1'b0;
      apb(1'b1, RTD_ADDR_CFG, 8'h12);
      apb(1'b1, RTD_ADDR_RTI, 8'h10);
      apb(1'b1, RTD_ADDR_STAT, 8'h01);
      repeat (3000) @(posedge clk);
      apb(1'b1, RTD_ADDR_RTI, 8'h10);
      d = cyc;
      wait_sig(1'b0, 4400, t);
      chk("write restart", (t - d) >= 4000, 1'b1); // write restart
      apb(1'b1, RTD_ADDR_CFG, 8'h13);
      apb(1'b1, RTD_ADDR_STAT, 8'h01);
      repeat (3000) @(posedge clk);
      osc_up_in <= 1'b0;
      d = cyc;
      wait_sig(1'b0, 4400, t);
      chk("loss restart", (t - d) >= 4000, 1'b1); // source loss
      apb(1'b0, RTD_ADDR_CFG, 8'h00);
      chk("source cleared", rdat, 32'h12); // auto clear
      osc_up_in <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b0, RTD_ADDR_STAT, 8'h00);
      chk("status up", rdat & 32'h6, 32'h6); // status set
      apb(1'b1, RTD_ADDR_PLL, 8'h10);
      apb(1'b0, RTD_ADDR_STAT, 8'h00);
      chk("status cleared", rdat & 32'h6, 32'h0); // write clears
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, RTD_ADDR_PLL, 8'h00);
      chk("reset mod", rdat, {24'h0, RTD_PLL_RESET}); // reset value
      apb(1'b0, RTD_ADDR_RTI, 8'h00);
      chk("reset div", rdat, {24'h0, RTD_RTI_RESET}); // reset off
      apb(1'b0, RTD_ADDR_CFG, 8'h00);
      chk("reset cfg", rdat, {27'h0, RTD_CFG_RESET}); // reset select
      chk("reset outputs", {periodic_irq, fm_amplitude}, 3'h0); // reset off
      results();
   end
endmodule
`default_nettype wire
